// *** rcac_autocal.sv ***
`timescale 1ns/1ps
module rcac_autocal (
  input wire logic clk_sys_i, // system clock, 50 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // register write data
  output logic [7:0] reg_rdata_o, // registered read data
  input wire logic sec_tick_i, // one-cycle pulse per second
  input wire logic xt_clk_i, // crystal oscillator level, async
  input wire logic rc_clk_i, // raw RC oscillator 128 Hz level, async
  input wire logic vdd_ok_i, // main supply above switchover_threshold, async
  input wire logic xt_fail_i, // crystal failure detector, async
  output logic xt_enable_o, // crystal oscillator enable
  output logic rc_active_o, // clocks taken from RC oscillator
  output logic backup_supply_o, // power moved to backup_supply
  output logic rc_filter_pin_o, // rc_filter_pin filter enable
  output logic [1:0] cal_range_o, // rc_cal_range to divider chain
  output logic [13:0] cal_offset_o, // rc_cal_offset to divider chain
  output logic cal_busy_o, // calibration cycle in progress
  output logic irq_o // calibration failure interrupt
);
  // ==========================================================================
  // input synchronisers
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic xt_prev;
  logic rc_prev;
  logic xt_rise;
  logic rc_rise;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      xt_prev <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      sync_a <= {xt_fail_i, vdd_ok_i, rc_clk_i, xt_clk_i};
      sync_b <= sync_a;
      xt_prev <= sync_b[0];
      rc_prev <= sync_b[1];
    end
  end

  assign xt_rise = sync_b[0] & ~xt_prev;
  assign rc_rise = sync_b[1] & ~rc_prev;

  // ==========================================================================
  // range and offset mapping
  function automatic logic [16:0] map_adj(input logic signed [22:0] adj);
    logic signed [22:0] ofs;
    logic fail;
    logic [1:0] rng;
    ofs = adj;
    fail = 1'b0;
    rng = 2'h0;
    if (adj < -rcac_pkg::ADJ_LIM_8) begin
      fail = 1'b1;
    end else if (adj < -rcac_pkg::ADJ_LIM_4) begin
      rng = 2'h3;
      ofs = adj >>> 3;
    end else if (adj < -rcac_pkg::ADJ_LIM_2) begin
      rng = 2'h2;
      ofs = adj >>> 2;
    end else if (adj < -rcac_pkg::ADJ_LIM_1) begin
      rng = 2'h1;
      ofs = adj >>> 1;
    end else if (adj < rcac_pkg::ADJ_LIM_1) begin
      rng = 2'h0;
    end else if (adj < rcac_pkg::ADJ_LIM_2) begin
      rng = 2'h1;
      ofs = adj >>> 1;
    end else if (adj < rcac_pkg::ADJ_LIM_4) begin
      rng = 2'h2;
      ofs = adj >>> 2;
    end else if (adj < rcac_pkg::ADJ_LIM_8) begin
      rng = 2'h3;
      ofs = adj >>> 3;
    end else begin
      fail = 1'b1;
    end
    return {fail, rng, ofs[13:0]};
  endfunction : map_adj

  // ==========================================================================
  // state
  rcac_pkg::rcac_state_e state, next_state;
  rcac_pkg::rcac_ctrl_s ctrl, next_ctrl;
  rcac_pkg::rcac_cal_s cal, next_cal;
  logic acf, next_acf;
  logic of_flag, next_of_flag;
  logic key_armed, next_key_armed;
  logic filter_on, next_filter_on;
  logic rc_active, next_rc_active;
  logic backup, next_backup;
  logic xt_en, next_xt_en;
  logic [10:0] period_cnt, next_period_cnt;
  logic [5:0] warm_cnt, next_warm_cnt;
  logic [11:0] rc_cnt, next_rc_cnt;
  logic [21:0] xt_cnt, next_xt_cnt;
  logic [7:0] rdata, next_rdata;
  logic start;
  logic [10:0] period_len;
  logic [16:0] mapped;
  logic wr_ctrl;

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_cal = cal;
    next_acf = acf;
    next_of_flag = of_flag;
    next_key_armed = key_armed;
    next_filter_on = filter_on;
    next_period_cnt = period_cnt;
    next_warm_cnt = warm_cnt;
    next_rc_cnt = rc_cnt;
    next_xt_cnt = xt_cnt;
    next_rdata = rdata;
    start = 1'b0;
    wr_ctrl = reg_wr_i && (reg_addr_i == rcac_pkg::ADDR_OSC_CTRL);
    mapped = map_adj($signed({1'b0, xt_cnt}) - rcac_pkg::XT_EXPECTED);

    // ------------------------------------------------------------------------
    // register writes
    if (reg_wr_i) begin
      next_key_armed = (reg_addr_i == rcac_pkg::ADDR_CFG_KEY) &&
                       (reg_wdata_i == rcac_pkg::KEY_FILTER);
      if (reg_addr_i == rcac_pkg::ADDR_CAL_UPPER) begin
        next_cal.range = reg_wdata_i[rcac_pkg::UPPER_RANGE_MSB:rcac_pkg::UPPER_RANGE_LSB];
        next_cal.offset[13:8] = reg_wdata_i[rcac_pkg::UPPER_OFS_MSB:0];
      end else if (reg_addr_i == rcac_pkg::ADDR_CAL_LOWER) begin
        next_cal.offset[7:0] = reg_wdata_i;
      end else if (wr_ctrl) begin
        next_ctrl.oscillator_select = reg_wdata_i[rcac_pkg::CTRL_OSCILLATOR_SELECT_BIT];
        next_ctrl.acal = reg_wdata_i[rcac_pkg::CTRL_ACAL_MSB:rcac_pkg::CTRL_ACAL_LSB];
        next_ctrl.battery_switch_bit = reg_wdata_i[rcac_pkg::CTRL_BOS_BIT];
        next_ctrl.calibration_failure_irq_enable = reg_wdata_i[rcac_pkg::CTRL_CALIBRATION_FAILURE_IRQ_ENABLE_BIT];
      end else if (reg_addr_i == rcac_pkg::ADDR_OSC_STAT) begin
        // flags clear by writing zero
        next_acf = acf & reg_wdata_i[rcac_pkg::STAT_ACF_BIT];
        next_of_flag = of_flag & reg_wdata_i[rcac_pkg::STAT_OF_BIT];
      end else if (reg_addr_i == rcac_pkg::ADDR_FILTER && key_armed) begin
        // only the enable code turns the filter on
        next_filter_on = (reg_wdata_i == rcac_pkg::FILTER_ON);
      end
    end

    // crystal failure detection, set wins over clear
    if (sync_b[3]) begin
      next_of_flag = 1'b1;
    end

    // ------------------------------------------------------------------------
    // interval timer
    period_len = (ctrl.acal == rcac_pkg::ACAL_512) ? rcac_pkg::PERIOD_512_S :
                 rcac_pkg::PERIOD_1024_S;
    // no periodic run for 00 or reserved 01
    if (ctrl.acal != rcac_pkg::ACAL_1024 && ctrl.acal != rcac_pkg::ACAL_512) begin
      next_period_cnt = 11'h000;
    end else if (sec_tick_i) begin
      if (period_cnt >= period_len - 11'h001) begin
        next_period_cnt = 11'h000;
        start = 1'b1;
      end else begin
        next_period_cnt = period_cnt + 11'h001;
      end
    end
    if (wr_ctrl && ctrl.acal == rcac_pkg::ACAL_OFF &&
        reg_wdata_i[rcac_pkg::CTRL_ACAL_MSB:rcac_pkg::CTRL_ACAL_LSB] != rcac_pkg::ACAL_OFF) begin
      start = 1'b1;
    end

    // ------------------------------------------------------------------------
    // calibration sequence
    case (state)
      rcac_pkg::ST_IDLE: begin
        if (start) begin
          next_state = rcac_pkg::ST_WARM;
          next_warm_cnt = 6'h00;
        end
      end
      rcac_pkg::ST_WARM: begin
        // warm-up plus window make the crystal on-time
        if (sec_tick_i) begin
          next_warm_cnt = warm_cnt + 6'h01;
          if (warm_cnt == rcac_pkg::WARM_S - 6'h01) begin
            next_state = rcac_pkg::ST_MEAS;
            next_rc_cnt = 12'h000;
            next_xt_cnt = 22'h000000;
          end
        end
      end
      rcac_pkg::ST_MEAS: begin
        // crystal cycles counted within an RC-timed window
        if (xt_rise) begin
          next_xt_cnt = xt_cnt + 22'h000001;
        end
        if (rc_rise) begin
          next_rc_cnt = rc_cnt + 12'h001;
          if (rc_cnt == rcac_pkg::MEAS_RC_CYCLES - 12'h001) begin
            next_state = rcac_pkg::ST_APPLY;
          end
        end
      end
      rcac_pkg::ST_APPLY: begin
        next_state = rcac_pkg::ST_IDLE;
        if (mapped[16]) begin
          next_acf = 1'b1;
        end else begin
          next_cal.range = mapped[15:14];
          next_cal.offset = mapped[13:0];
        end
      end
      default: begin
        next_state = rcac_pkg::ST_IDLE;
      end
    endcase
    // a failed crystal gives no usable reference
    if (state != rcac_pkg::ST_IDLE && state != rcac_pkg::ST_APPLY && of_flag) begin
      next_state = rcac_pkg::ST_IDLE;
    end
    if (acf) begin
      if (!(reg_wr_i && reg_addr_i == rcac_pkg::ADDR_OSC_STAT)) begin
        next_acf = 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // oscillator selection
    // supply loss with battery bit moves to backup and RC
    next_backup = ctrl.battery_switch_bit & ~sync_b[2];
    next_rc_active = rc_active;
    // change only at a second boundary
    if (sec_tick_i) begin
      // selection follows select bit and supply
      next_rc_active = ctrl.oscillator_select | (ctrl.battery_switch_bit & ~sync_b[2]);
    end
    // crystal runs when clocking or calibrating
    next_xt_en = ~next_rc_active | (next_state != rcac_pkg::ST_IDLE);

    // ------------------------------------------------------------------------
    // read data
    if (reg_rd_i) begin
      if (reg_addr_i == rcac_pkg::ADDR_CAL_UPPER) begin
        next_rdata = {cal.range, cal.offset[13:8]};
      end else if (reg_addr_i == rcac_pkg::ADDR_CAL_LOWER) begin
        next_rdata = cal.offset[7:0];
      end else if (reg_addr_i == rcac_pkg::ADDR_OSC_CTRL) begin
        next_rdata = {ctrl.oscillator_select, ctrl.acal, ctrl.battery_switch_bit, 3'h0, ctrl.calibration_failure_irq_enable};
      end else if (reg_addr_i == rcac_pkg::ADDR_OSC_STAT) begin
        next_rdata = {3'h0, rc_active, 2'h0, acf, of_flag};
      end else if (reg_addr_i == rcac_pkg::ADDR_FILTER) begin
        next_rdata = filter_on ? rcac_pkg::FILTER_ON : rcac_pkg::FILTER_OFF;
      end else begin
        next_rdata = rcac_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= rcac_pkg::ST_IDLE;
      ctrl <= '0;
      cal <= {rcac_pkg::RST_CAL_RANGE, rcac_pkg::RST_CAL_OFFSET};
      acf <= 1'b0;
      of_flag <= 1'b0;
      key_armed <= 1'b0;
      filter_on <= 1'b0;
      rc_active <= 1'b0;
      backup <= 1'b0;
      xt_en <= 1'b1;
      period_cnt <= 11'h000;
      warm_cnt <= 6'h00;
      rc_cnt <= 12'h000;
      xt_cnt <= 22'h000000;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      cal <= next_cal;
      acf <= next_acf;
      of_flag <= next_of_flag;
      key_armed <= next_key_armed;
      filter_on <= next_filter_on;
      rc_active <= next_rc_active;
      backup <= next_backup;
      xt_en <= next_xt_en;
      period_cnt <= next_period_cnt;
      warm_cnt <= next_warm_cnt;
      rc_cnt <= next_rc_cnt;
      xt_cnt <= next_xt_cnt;
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_o = rdata;
  assign xt_enable_o = xt_en;
  assign rc_active_o = rc_active;
  assign backup_supply_o = backup;
  assign rc_filter_pin_o = filter_on;
  assign cal_range_o = cal.range;
  assign cal_offset_o = cal.offset;
  assign cal_busy_o = (state != rcac_pkg::ST_IDLE);
  assign irq_o = acf & ctrl.calibration_failure_irq_enable;
endmodule : rcac_autocal

// *** rcac_pkg.sv ***
package rcac_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CAL_UPPER = 8'h15;
  localparam logic [7:0] ADDR_CAL_LOWER = 8'h16;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_OSC_STAT = 8'h1D;
  localparam logic [7:0] ADDR_CFG_KEY = 8'h1F;
  localparam logic [7:0] ADDR_FILTER = 8'h26;
  // ==========================================================================
  // key and filter codes
  localparam logic [7:0] KEY_FILTER = 8'h9D;
  localparam logic [7:0] FILTER_ON = 8'hA0;
  localparam logic [7:0] FILTER_OFF = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ==========================================================================
  // field positions
  localparam int CTRL_OSCILLATOR_SELECT_BIT = 7;
  localparam int CTRL_ACAL_MSB = 6;
  localparam int CTRL_ACAL_LSB = 5;
  localparam int CTRL_BOS_BIT = 4;
  localparam int CTRL_CALIBRATION_FAILURE_IRQ_ENABLE_BIT = 0;
  localparam int STAT_ACTIVE_OSCILLATOR_STATUS_BIT = 4;
  localparam int STAT_ACF_BIT = 1;
  localparam int STAT_OF_BIT = 0;
  localparam int UPPER_RANGE_MSB = 7;
  localparam int UPPER_RANGE_LSB = 6;
  localparam int UPPER_OFS_MSB = 5;
  // ==========================================================================
  // interval codes and timing
  localparam logic [1:0] ACAL_OFF = 2'h0;
  localparam logic [1:0] ACAL_1024 = 2'h2;
  localparam logic [1:0] ACAL_512 = 2'h3;
  localparam logic [10:0] PERIOD_1024_S = 11'h400;
  localparam logic [10:0] PERIOD_512_S = 11'h200;
  localparam int CAL_ON_S = 50;
  localparam int RC_NOMINAL_HZ = 128;
  localparam logic [11:0] MEAS_RC_CYCLES = 12'h800;
  localparam int MEAS_S = 2048 / RC_NOMINAL_HZ;
  localparam logic [5:0] WARM_S = 6'(CAL_ON_S - MEAS_S);
  // 16 s of nominal crystal at 32768 Hz: one count equals one 2^-19 step
  localparam logic signed [22:0] XT_EXPECTED = 23'sh080000;
  localparam logic signed [22:0] ADJ_LIM_8 = 23'sh010000;
  localparam logic signed [22:0] ADJ_LIM_4 = 23'sh008000;
  localparam logic signed [22:0] ADJ_LIM_2 = 23'sh004000;
  localparam logic signed [22:0] ADJ_LIM_1 = 23'sh002000;
  // neutral power-up calibration
  localparam logic [1:0] RST_CAL_RANGE = 2'h0;
  localparam logic [13:0] RST_CAL_OFFSET = 14'h0000;
  // ==========================================================================
  // types
  typedef struct packed {
    logic oscillator_select;
    logic [1:0] acal;
    logic battery_switch_bit;
    logic calibration_failure_irq_enable;
  } rcac_ctrl_s;

  typedef struct packed {
    logic [1:0] range;
    logic [13:0] offset;
  } rcac_cal_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_MEAS = 2'b11,
    ST_APPLY = 2'b10
  } rcac_state_e;
endpackage : rcac_pkg

// *** rcac_autocal_props.sv ***
`timescale 1ns/1ps
// ==================================================
// checker
module rcac_chk (
  input wire logic clk_sys_i, // clock
  input wire logic nrst_i, // reset
  input wire logic reg_wr_i, // write strobe
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic sec_tick_i, // second tick
  input wire logic vdd_ok_i, // supply good
  input wire logic xt_enable_o, // crystal on
  input wire logic rc_active_o, // rc clocking
  input wire logic backup_supply_o, // on backup
  input wire logic rc_filter_pin_o, // filter on
  input wire logic [1:0] cal_range_o, // range
  input wire logic [13:0] cal_offset_o, // offset
  input wire logic cal_busy_o, // cycle running
  input wire logic irq_o // failure interrupt
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic armed;
  logic next_armed;
  logic [1:0] acal;
  logic [1:0] next_acal;
  logic ctrl_wr;
  logic flt_ok;
  assign ctrl_wr = reg_wr_i && (reg_addr_i == rcac_pkg::ADDR_OSC_CTRL);
  assign flt_ok = reg_wr_i && (reg_addr_i == rcac_pkg::ADDR_FILTER) && armed;
  // shadow of key state and interval field
  always_comb begin
    next_armed = armed;
    next_acal = acal;
    if (reg_wr_i)
      next_armed = (reg_addr_i == rcac_pkg::ADDR_CFG_KEY) && (reg_wdata_i == rcac_pkg::KEY_FILTER);
    if (ctrl_wr)
      next_acal = reg_wdata_i[6:5];
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed <= 1'b0;
      acal <= 2'h0;
    end else begin
      armed <= next_armed;
      acal <= next_acal;
    end
  end
  xt_busy_a: assert property (cal_busy_o && $past(cal_busy_o) |-> xt_enable_o)
    else $error("crystal off during cycle");
  xt_off_a: assert property (rc_active_o && $past(rc_active_o) && !cal_busy_o
    && !$past(cal_busy_o) |-> !xt_enable_o)
    else $error("crystal on while rc idle");
  osc_tick_a: assert property ($changed(rc_active_o) |-> $past(sec_tick_i))
    else $error("oscillator switch off tick");
  vdd_back_a: assert property (vdd_ok_i [*4] |=> !backup_supply_o)
    else $error("backup kept with supply good");
  start_wr_a: assert property (ctrl_wr && reg_wdata_i[6:5] != 2'h0 && acal == 2'h0
    && !cal_busy_o |=> cal_busy_o)
    else $error("no cycle on interval write");
  no_start_a: assert property ($rose(cal_busy_o) && $past(acal) == 2'h0 |-> $past(ctrl_wr))
    else $error("cycle with interval off");
  key_gate_a: assert property ($changed(rc_filter_pin_o) |-> $past(flt_ok))
    else $error("filter changed without key");
  filter_val_a: assert property (flt_ok && reg_wdata_i == rcac_pkg::FILTER_ON
    |=> rc_filter_pin_o)
    else $error("filter not enabled");
  cal_keep_a: assert property ($changed({cal_range_o, cal_offset_o})
    |-> $past(reg_wr_i) || $past(cal_busy_o))
    else $error("calibration changed unprompted");
  // failure raises the interrupt and leaves calibration alone
  fail_keep_a: assert property ($rose(irq_o) && !$past(reg_wr_i)
    |-> $stable({cal_range_o, cal_offset_o}))
    else $error("calibration changed on failure");
  cover property ($rose(cal_busy_o));
  cover property ($rose(backup_supply_o));
  cover property ($rose(rc_filter_pin_o));
endmodule : rcac_chk

// *** rcac_host.sv ***
`timescale 1ns/1ps
// ==================================================
// host controller model
module rcac_host (
  input wire logic clk_sys_i, // clock
  input wire logic [7:0] rdata_i, // read data
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic [7:0] addr_o, // address
  output logic [7:0] wdata_o // write data
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    // idle lines show the inverse, not stale values
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
  task automatic filt(input logic [7:0] v);
    wr(rcac_pkg::ADDR_CFG_KEY, rcac_pkg::KEY_FILTER);
    wr(rcac_pkg::ADDR_FILTER, v);
  endtask : filt
endmodule : rcac_host

// *** test_rcac_autocal.sv ***
`timescale 1ns/1ps
module test_rcac_autocal;
  logic clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, sec_tick_i, xt_clk_i, rc_clk_i, vdd_ok_i;
  logic xt_fail_i, xt_enable_o, rc_active_o, backup_supply_o, rc_filter_pin_o, cal_busy_o, irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [1:0] cal_range_o;
  logic [13:0] cal_offset_o;
  int bad_count, samples_checked, ticks, cycles;
  // about 72000 cycles of tests plus margin
  localparam int TIMEOUT_CYCLES = 90000;
  rcac_autocal uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sec_tick_i(sec_tick_i), .xt_clk_i(xt_clk_i),
    .rc_clk_i(rc_clk_i), .vdd_ok_i(vdd_ok_i), .xt_fail_i(xt_fail_i),
    .xt_enable_o(xt_enable_o), .rc_active_o(rc_active_o), .backup_supply_o(backup_supply_o),
    .rc_filter_pin_o(rc_filter_pin_o), .cal_range_o(cal_range_o), .cal_offset_o(cal_offset_o),
    .cal_busy_o(cal_busy_o), .irq_o(irq_o));
  rcac_host host (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  // ==================================================
  // clock, oscillators, ticks, timeout
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {nrst_i, sec_tick_i, xt_clk_i, rc_clk_i, xt_fail_i} = 5'h00;
    vdd_ok_i = 1'b1;
    ticks = 0;
    cycles = 0;
  end
  always @(negedge clk_sys_i) begin
    cycles = cycles + 1;
    rc_clk_i = cycles[1];
    xt_clk_i = cycles[3];
    sec_tick_i = (cycles % 20 == 0);
    if (cycles % 20 == 0)
      ticks = ticks + 1;
    if (cycles > TIMEOUT_CYCLES) begin
      bad_count++;
      $display("MISMATCH t=%0t timeout got %h exp %h", $time, cycles, TIMEOUT_CYCLES);
      tally_and_finish();
    end
  end
  // ==================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk(16'(d), 16'(exp));
  endtask : rdc
  task automatic tick2();
    repeat (2) @(posedge sec_tick_i);
    repeat (2) @(negedge clk_sys_i);
  endtask : tick2
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (cal_busy_o !== lvl && n < 25000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(cal_busy_o), 16'(lvl));
  endtask : wait_busy
  // ==================================================
  // scenarios
  task automatic t_reset();
    chk(16'({xt_enable_o, rc_active_o, backup_supply_o, rc_filter_pin_o, cal_busy_o, irq_o}),
      16'h0020);
    rdc(rcac_pkg::ADDR_CAL_UPPER, 8'h00);
    rdc(rcac_pkg::ADDR_CAL_LOWER, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_filter();
    host.wr(rcac_pkg::ADDR_CFG_KEY, rcac_pkg::KEY_FILTER);
    rdc(8'h40, rcac_pkg::READ_ZERO);
    host.wr(rcac_pkg::ADDR_FILTER, rcac_pkg::FILTER_ON);
    chk(16'(rc_filter_pin_o), 16'h0001);
    rdc(rcac_pkg::ADDR_FILTER, rcac_pkg::FILTER_ON);
    host.wr(rcac_pkg::ADDR_CFG_KEY, rcac_pkg::KEY_FILTER);
    host.wr(rcac_pkg::ADDR_CAL_LOWER, 8'h00);
    host.wr(rcac_pkg::ADDR_FILTER, rcac_pkg::FILTER_OFF);
    chk(16'(rc_filter_pin_o), 16'h0001);
    host.filt(rcac_pkg::FILTER_OFF);
    chk(16'(rc_filter_pin_o), 16'h0000);
    $display("test filter done");
  endtask : t_filter
  task automatic t_osc();
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'h80);
    tick2();
    chk(16'({rc_active_o, xt_enable_o, cal_busy_o}), 16'h0004);
    rdc(rcac_pkg::ADDR_OSC_STAT, 8'h10);
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'h10);
    tick2();
    chk(16'({rc_active_o, xt_enable_o}), 16'h0001);
    vdd_ok_i = 1'b0;
    tick2();
    chk(16'({backup_supply_o, rc_active_o, xt_enable_o}), 16'h0006);
    vdd_ok_i = 1'b1;
    tick2();
    chk(16'({backup_supply_o, rc_active_o, xt_enable_o}), 16'h0001);
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'h00);
    $display("test oscillator done");
  endtask : t_osc
  task automatic t_fail();
    host.wr(rcac_pkg::ADDR_CAL_UPPER, 8'h47);
    host.wr(rcac_pkg::ADDR_CAL_LOWER, 8'h5A);
    chk({cal_range_o, cal_offset_o}, 16'h475A);
    // select 1, interval 10, interrupt enabled
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'hC1);
    chk(16'({cal_busy_o, xt_enable_o}), 16'h0003);
    wait_busy(1'b0);
    chk(16'(irq_o), 16'h0001);
    rdc(rcac_pkg::ADDR_OSC_STAT, 8'h12);
    chk({cal_range_o, cal_offset_o}, 16'h475A);
    rdc(rcac_pkg::ADDR_CAL_UPPER, 8'h47);
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'h41);
    tick2();
    chk(16'({rc_active_o, xt_enable_o}), 16'h0001);
    rdc(rcac_pkg::ADDR_OSC_STAT, 8'h02);
    host.wr(rcac_pkg::ADDR_OSC_STAT, 8'h00);
    host.wr(rcac_pkg::ADDR_OSC_CTRL, 8'h00);
    chk(16'(irq_o), 16'h0000);
    rdc(rcac_pkg::ADDR_OSC_STAT, 8'h00);
    $display("test failure done");
  endtask : t_fail
  task automatic t_period(input logic [1:0] c, input logic [15:0] p);
    int t0;
    host.wr(rcac_pkg::ADDR_OSC_CTRL, {1'b0, c, 5'h00});
    chk(16'(cal_busy_o), 16'h0001);
    wait_busy(1'b0);
    wait_busy(1'b1);
    t0 = ticks;
    wait_busy(1'b0);
    wait_busy(1'b1);
    chk(16'(ticks - t0), p);
    $display("test period done");
  endtask : t_period
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    t_reset();
    t_filter();
    t_osc();
    t_fail();
    t_period(rcac_pkg::ACAL_512, 16'h0200);
    t_period(rcac_pkg::ACAL_1024, 16'h0400);
    tally_and_finish();
  end
endmodule : test_rcac_autocal
bind rcac_autocal rcac_chk chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .sec_tick_i(sec_tick_i),
  .vdd_ok_i(vdd_ok_i), .xt_enable_o(xt_enable_o), .rc_active_o(rc_active_o),
  .backup_supply_o(backup_supply_o), .rc_filter_pin_o(rc_filter_pin_o),
  .cal_range_o(cal_range_o), .cal_offset_o(cal_offset_o), .cal_busy_o(cal_busy_o),
  .irq_o(irq_o));
